/* File: hw/ldt_defs.svh */
// Register offsets, fields, reset values and timing constants
`ifndef LDT_DEFS_SVH
`define LDT_DEFS_SVH

`define LDT_ADDR_W        8
`define LDT_DATA_W        8

`define LDT_OFS_GEN_CTRL  8'h07
`define LDT_OFS_CONV_CTL0 8'h41
`define LDT_OFS_CONV_CTL1 8'h42
`define LDT_OFS_CONV_DATA 8'h43
`define LDT_OFS_RTZ_CTRL  8'h44
`define LDT_OFS_HTR_CTRL  8'h49
`define LDT_OFS_HTR_SETPT 8'h4a
`define LDT_OFS_HEATER_LEVEL_READBACK  8'h4b
`define LDT_OFS_TRIP_THR  8'h4c
`define LDT_OFS_RESUME_TH 8'h4d
`define LDT_OFS_THERM_DAT 8'h4e

`define LDT_GEN_CONV_EN   3
`define LDT_GEN_TSD_EN    5
`define LDT_C0_CONV_EN    6
`define LDT_C1_TEST_DAC   7
`define LDT_C1_PEAK_INIT  6
`define LDT_C1_PEAK_LOAD  1
`define LDT_RTZ_EN3       7
`define LDT_RTZ_EN2       6
`define LDT_RTZ_EN1       5
`define LDT_RTZ_DLY_HI    4
`define LDT_RTZ_DLY_LO    3
`define LDT_RTZ_WID_HI    2
`define LDT_RTZ_WID_LO    0
`define LDT_HTR_SMP_HI    7
`define LDT_HTR_SMP_LO    5
`define LDT_HTR_REF_HI    4
`define LDT_HTR_REF_LO    3
`define LDT_HTR_MODE_HI   2
`define LDT_HTR_MODE_LO   0

`define LDT_RST_ZERO      8'h00
`define LDT_RST_TRIP      8'h40
`define LDT_RST_RESUME    8'h60
`define LDT_RST_THERM     8'hff
`define LDT_RST_RTZ_DLY   4'h0
`define LDT_RST_RTZ_WID   4'h1

`define LDT_SMP_CNT_W     10
`define LDT_SMP_BASE      10'h004

`endif

/* File: hw/ldt_pkg.sv */
// Types for the laser driver control block
package ldt_pkg;

  typedef enum logic [1:0] {
    LDT_TH_RUN  = 2'b01,
    LDT_TH_SHUT = 2'b10
  } ldt_therm_t;

  typedef enum logic [2:0] {
    LDT_HM_OFF     = 3'h0,
    LDT_HM_PWM     = 3'h1,
    LDT_HM_CONV    = 3'h2,
    LDT_HM_OFF_ALT = 3'h3,
    LDT_HM_PULSED  = 3'h4,
    LDT_HM_FULL    = 3'h5,
    LDT_HM_RSV6    = 3'h6,
    LDT_HM_RSV7    = 3'h7
  } ldt_htr_mode_t;

  typedef logic [7:0] ldt_byte_t;

endpackage

/* File: hw/ldt_ctrl.sv */
// Register bank, return-to-zero setup, heater control and thermal shutdown
//
// Overview of operation
// - Data write loads peak detector when selected
// - Data write loads test converter, monitored
// - One return-to-zero enable per channel
// - Shared delay code gives 0,1,3,5 sixteenths
// - Shared width is code plus one sixteenths
// - Sample code sets clocks between samples
// - Two-bit heater reference current select
// - Three-bit heater method select
// - Eight-bit heater target set point
// - Heater readback is read-only live value
// - Shutdown when thermal data below trip
// - Recover when thermal data above resume
// - Measure only with both converter enables
// - Shutdown acts only when enabled
// - Smaller temperature code means hotter
// - Thermal data register returns die temperature
`timescale 1ns/1ps
`include "ldt_defs.svh"

module ldt_ctrl
(
  // Clock and reset
  input  wire logic               sys_clk,
  input  wire logic               rst_b,
  // Register port
  input  wire logic [7:0]         reg_addr,
  input  wire ldt_pkg::ldt_byte_t reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic [7:0]              reg_rdata,
  // Converter side
  input  wire ldt_pkg::ldt_byte_t conv_result,
  output logic                    conv_meas_en,
  output logic                    peak_load,
  output logic [7:0]              peak_load_data,
  output logic [1:0]              peak_detect_mode,
  output logic [7:0]              test_dac_level,
  // Return-to-zero setup
  output logic                    return_to_zero_en_ch1,
  output logic                    return_to_zero_en_ch2,
  output logic                    return_to_zero_en_ch3,
  output logic [3:0]              return_to_zero_delay,
  output logic [3:0]              return_to_zero_width,
  // Heater
  input  wire ldt_pkg::ldt_byte_t heater_level,
  output logic                    heater_sample,
  output logic [1:0]              heater_ref_sel,
  output ldt_pkg::ldt_htr_mode_t  heater_mode,
  output logic                    heater_active,
  output logic [7:0]              heater_target_setpoint,
  // Thermal
  input  wire ldt_pkg::ldt_byte_t die_temp,
  input  wire logic               die_temp_valid,
  output logic                    thermal_shutdown
);

  import ldt_pkg::*;

  // Delay code to sixteenths of a clock period
  function automatic logic [3:0] rtz_delay_16(input logic [1:0] code);
    logic [3:0] r;
    r = 4'h0;
    case (code)
      2'h1:    r = 4'h1;
      2'h2:    r = 4'h3;
      2'h3:    r = 4'h5;
      default: r = 4'h0;
    endcase
    return r;
  endfunction

  // Clocks between heater samples, 4 shifted by code
  function automatic logic [`LDT_SMP_CNT_W-1:0] smp_interval(input logic [2:0] code);
    return `LDT_SMP_BASE << code;
  endfunction

  // Heater methods that actually drive the heater
  function automatic logic htr_mode_on(input ldt_htr_mode_t m);
    logic r;
    r = 1'b0;
    case (m)
      LDT_HM_PWM,
      LDT_HM_PULSED,
      LDT_HM_FULL: r = 1'b1;
      default:     r = 1'b0;
    endcase
    return r;
  endfunction

  // Write strobe aimed at one register offset
  function automatic logic wr_hit(input logic       wr,
                                  input logic [7:0] addr,
                                  input logic [7:0] ofs);
    return wr && (addr == ofs);
  endfunction

  // Register storage
  ldt_byte_t                 gen_ctrl_ff;
  ldt_byte_t                 conv_ctl0_ff;
  ldt_byte_t                 conv_ctl1_ff;
  ldt_byte_t                 conv_last_wr_ff;
  ldt_byte_t                 rtz_ctrl_ff;
  ldt_byte_t                 htr_ctrl_ff;
  ldt_byte_t                 htr_setpt_ff;
  ldt_byte_t                 trip_thr_ff;
  ldt_byte_t                 resume_thr_ff;
  ldt_byte_t                 therm_data_ff;
  ldt_byte_t                 rdata_ff;
  ldt_byte_t                 nxt_rdata;
  logic                      peak_load_ff;
  ldt_byte_t                 peak_data_ff;
  ldt_byte_t                 test_dac_ff;
  logic [`LDT_SMP_CNT_W-1:0] smp_cnt_ff;
  logic                      smp_pulse_ff;
  ldt_therm_t                therm_st_ff;
  ldt_therm_t                nxt_therm_st;
  logic                      wr_gen;
  logic                      wr_ctl0;
  logic                      wr_ctl1;
  logic                      wr_data;
  logic                      wr_rtz;
  logic                      wr_htr;
  logic                      wr_setpt;
  logic                      wr_trip;
  logic                      wr_resume;
  logic                      meas_en;
  logic                      tsd_en;
  logic                      smp_run;
  logic [`LDT_SMP_CNT_W-1:0] smp_last;
  logic [3:0]                rtz_dly_ff;
  logic [3:0]                rtz_wid_ff;
  logic                      meas_en_ff;
  logic                      nxt_meas_en;
  ldt_htr_mode_t             htr_mode;

  assign wr_gen    = wr_hit(reg_wr, reg_addr, `LDT_OFS_GEN_CTRL);
  assign wr_ctl0   = wr_hit(reg_wr, reg_addr, `LDT_OFS_CONV_CTL0);
  assign wr_ctl1   = wr_hit(reg_wr, reg_addr, `LDT_OFS_CONV_CTL1);
  assign wr_data   = wr_hit(reg_wr, reg_addr, `LDT_OFS_CONV_DATA);
  assign wr_rtz    = wr_hit(reg_wr, reg_addr, `LDT_OFS_RTZ_CTRL);
  assign wr_htr    = wr_hit(reg_wr, reg_addr, `LDT_OFS_HTR_CTRL);
  assign wr_setpt  = wr_hit(reg_wr, reg_addr, `LDT_OFS_HTR_SETPT);
  assign wr_trip   = wr_hit(reg_wr, reg_addr, `LDT_OFS_TRIP_THR);
  assign wr_resume = wr_hit(reg_wr, reg_addr, `LDT_OFS_RESUME_TH);

  // Configuration registers
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      gen_ctrl_ff   <= `LDT_RST_ZERO;
      conv_ctl0_ff  <= `LDT_RST_ZERO;
      rtz_ctrl_ff   <= `LDT_RST_ZERO;
      htr_ctrl_ff   <= `LDT_RST_ZERO;
      htr_setpt_ff  <= `LDT_RST_ZERO;
      trip_thr_ff   <= `LDT_RST_TRIP;
      resume_thr_ff <= `LDT_RST_RESUME;
    end
    else
    begin
      if (wr_gen)
        gen_ctrl_ff <= reg_wdata;
      if (wr_ctl0)
        conv_ctl0_ff <= reg_wdata;
      if (wr_rtz)
        rtz_ctrl_ff <= reg_wdata;
      if (wr_htr)
        htr_ctrl_ff <= reg_wdata;
      if (wr_setpt)
        htr_setpt_ff <= reg_wdata;
      if (wr_trip)
        trip_thr_ff <= reg_wdata;
      if (wr_resume)
        resume_thr_ff <= reg_wdata;
    end
  end

  // Return-to-zero timing flops, loaded with the control write
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rtz_dly_ff <= `LDT_RST_RTZ_DLY;
      rtz_wid_ff <= `LDT_RST_RTZ_WID;
    end
    else if (wr_rtz)
    begin
      rtz_dly_ff <= rtz_delay_16(reg_wdata[`LDT_RTZ_DLY_HI:`LDT_RTZ_DLY_LO]);
      rtz_wid_ff <= {1'b0, reg_wdata[`LDT_RTZ_WID_HI:`LDT_RTZ_WID_LO]} + 4'h1;
    end
  end

  // Converter control 1; peak init bit clears itself after one cycle
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      conv_ctl1_ff <= `LDT_RST_ZERO;
    else if (wr_ctl1)
      conv_ctl1_ff <= reg_wdata;
    else if (conv_ctl1_ff[`LDT_C1_PEAK_INIT])
      conv_ctl1_ff[`LDT_C1_PEAK_INIT] <= 1'b0;
  end

  // Routing of converter data writes
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      conv_last_wr_ff <= `LDT_RST_ZERO;
      peak_load_ff    <= 1'b0;
      peak_data_ff    <= `LDT_RST_ZERO;
      test_dac_ff     <= `LDT_RST_ZERO;
    end
    else
    begin
      peak_load_ff <= 1'b0;
      if (wr_data)
        conv_last_wr_ff <= reg_wdata;
      if (wr_data && conv_ctl1_ff[`LDT_C1_PEAK_LOAD])
      begin
        peak_load_ff <= 1'b1;
        peak_data_ff <= reg_wdata;
      end
      else if (conv_ctl1_ff[`LDT_C1_PEAK_INIT])
      begin
        peak_load_ff <= 1'b1;
        peak_data_ff <= conv_last_wr_ff;
      end
      if (wr_data && conv_ctl1_ff[`LDT_C1_TEST_DAC])
        test_dac_ff <= reg_wdata;
    end
  end

  // Measured die temperature, refreshed only while converter runs
  assign nxt_meas_en = (wr_gen ? reg_wdata[`LDT_GEN_CONV_EN] : gen_ctrl_ff[`LDT_GEN_CONV_EN])
                       && (wr_ctl0 ? reg_wdata[`LDT_C0_CONV_EN] : conv_ctl0_ff[`LDT_C0_CONV_EN]);

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      meas_en_ff <= 1'b0;
    else
      meas_en_ff <= nxt_meas_en;
  end

  assign meas_en = meas_en_ff;

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      therm_data_ff <= `LDT_RST_THERM;
    else if (die_temp_valid && meas_en)
      therm_data_ff <= die_temp;
  end

  // Thermal shutdown with hysteresis; low code is hot
  assign tsd_en = gen_ctrl_ff[`LDT_GEN_TSD_EN];

  always_comb
  begin
    nxt_therm_st = therm_st_ff;
    case (therm_st_ff)
      LDT_TH_RUN:
      begin
        if (tsd_en && (therm_data_ff < trip_thr_ff))
          nxt_therm_st = LDT_TH_SHUT;
      end
      LDT_TH_SHUT:
      begin
        if (!tsd_en)
          nxt_therm_st = LDT_TH_RUN;
        else if (therm_data_ff > resume_thr_ff)
          nxt_therm_st = LDT_TH_RUN;
      end
      default:
        nxt_therm_st = LDT_TH_RUN;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      therm_st_ff <= LDT_TH_RUN;
    else
      therm_st_ff <= nxt_therm_st;
  end

  // Heater sample interval counter
  assign htr_mode = ldt_htr_mode_t'(htr_ctrl_ff[`LDT_HTR_MODE_HI:`LDT_HTR_MODE_LO]);
  assign smp_run  = htr_mode_on(htr_mode);
  assign smp_last = smp_interval(htr_ctrl_ff[`LDT_HTR_SMP_HI:`LDT_HTR_SMP_LO])
                    - `LDT_SMP_CNT_W'(1);

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      smp_cnt_ff   <= '0;
      smp_pulse_ff <= 1'b0;
    end
    else if (!smp_run || wr_htr)
    begin
      smp_cnt_ff   <= '0;
      smp_pulse_ff <= 1'b0;
    end
    else if (smp_cnt_ff >= smp_last)
    begin
      smp_cnt_ff   <= '0;
      smp_pulse_ff <= 1'b1;
    end
    else
    begin
      smp_cnt_ff   <= smp_cnt_ff + `LDT_SMP_CNT_W'(1);
      smp_pulse_ff <= 1'b0;
    end
  end

  // Read mux; answer stands one cycle after the strobe only
  always_comb
  begin
    nxt_rdata = `LDT_RST_ZERO;
    case (reg_addr)
      `LDT_OFS_GEN_CTRL:  nxt_rdata = gen_ctrl_ff;
      `LDT_OFS_CONV_CTL0: nxt_rdata = conv_ctl0_ff;
      `LDT_OFS_CONV_CTL1: nxt_rdata = conv_ctl1_ff;
      `LDT_OFS_CONV_DATA: nxt_rdata = conv_result;
      `LDT_OFS_RTZ_CTRL:  nxt_rdata = rtz_ctrl_ff;
      `LDT_OFS_HTR_CTRL:  nxt_rdata = htr_ctrl_ff;
      `LDT_OFS_HTR_SETPT: nxt_rdata = htr_setpt_ff;
      `LDT_OFS_HEATER_LEVEL_READBACK:  nxt_rdata = heater_level;
      `LDT_OFS_TRIP_THR:  nxt_rdata = trip_thr_ff;
      `LDT_OFS_RESUME_TH: nxt_rdata = resume_thr_ff;
      `LDT_OFS_THERM_DAT: nxt_rdata = therm_data_ff;
      default:            nxt_rdata = `LDT_RST_ZERO;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      rdata_ff <= `LDT_RST_ZERO;
    else if (reg_rd)
      rdata_ff <= nxt_rdata;
    else
      rdata_ff <= `LDT_RST_ZERO;
  end

  // Outputs
  assign reg_rdata             = rdata_ff;
  assign conv_meas_en          = meas_en;
  assign peak_load             = peak_load_ff;
  assign peak_load_data        = peak_data_ff;
  assign peak_detect_mode      = conv_ctl1_ff[1:0];
  assign test_dac_level        = test_dac_ff;
  assign return_to_zero_en_ch1 = rtz_ctrl_ff[`LDT_RTZ_EN1];
  assign return_to_zero_en_ch2 = rtz_ctrl_ff[`LDT_RTZ_EN2];
  assign return_to_zero_en_ch3 = rtz_ctrl_ff[`LDT_RTZ_EN3];
  assign return_to_zero_delay  = rtz_dly_ff;
  assign return_to_zero_width  = rtz_wid_ff;
  assign heater_sample         = smp_pulse_ff;
  assign heater_ref_sel        = htr_ctrl_ff[`LDT_HTR_REF_HI:`LDT_HTR_REF_LO];
  assign heater_mode           = htr_mode;
  assign heater_active         = smp_run;
  assign heater_target_setpoint = htr_setpt_ff;
  assign thermal_shutdown      = (therm_st_ff == LDT_TH_SHUT);

endmodule

/* File: tb/ldt_chk.sv */
// Port checker for the laser driver control block
`timescale 1ns/1ps
module ldt_chk
(
  // Clock and reset
  input wire logic               sys_clk,
  input wire logic               rst_b,
  // Register port
  input wire logic [7:0]         reg_addr,
  input wire ldt_pkg::ldt_byte_t reg_wdata,
  input wire logic               reg_wr,
  // Watched signals
  input wire logic               conv_meas_en,
  input wire logic               peak_load,
  input wire logic [7:0]         peak_load_data,
  input wire logic [7:0]         test_dac_level,
  input wire logic [3:0]         return_to_zero_delay,
  input wire logic [3:0]         return_to_zero_width,
  input wire ldt_pkg::ldt_byte_t die_temp,
  input wire logic               die_temp_valid,
  input wire logic               thermal_shutdown
);
  import ldt_pkg::*;
  ldt_byte_t  trip_ff;
  ldt_byte_t  resume_ff;
  ldt_byte_t  wd_ff;
  logic [1:0] sel_ff;
  logic       tsd_en_ff;
  // Shadow of the registers the rules depend on
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      trip_ff   <= 8'h40;
      resume_ff <= 8'h60;
      sel_ff    <= 2'h0;
      tsd_en_ff <= 1'b0;
      wd_ff     <= 8'h00;
    end
    else
    begin
      wd_ff <= reg_wdata;
      if (reg_wr && reg_addr == 8'h4c)
        trip_ff <= reg_wdata;
      if (reg_wr && reg_addr == 8'h4d)
        resume_ff <= reg_wdata;
      if (reg_wr && reg_addr == 8'h42)
        sel_ff <= {reg_wdata[7], reg_wdata[1]};
      if (reg_wr && reg_addr == 8'h07)
        tsd_en_ff <= reg_wdata[5];
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  sequence s_wr(a);
    reg_wr && reg_addr == a;
  endsequence
  sequence s_hot;
    die_temp_valid && conv_meas_en && tsd_en_ff && die_temp < trip_ff && !reg_wr
      ##1 !reg_wr;
  endsequence
  sequence s_cool;
    die_temp_valid && conv_meas_en && die_temp > resume_ff && !reg_wr ##1 !reg_wr;
  endsequence
  property p_peak;
    s_wr(8'h43) ##0 sel_ff[0] |=> peak_load && peak_load_data == wd_ff;
  endproperty
  property p_dac;
    s_wr(8'h43) ##0 sel_ff[1] |=> test_dac_level == wd_ff;
  endproperty
  property p_rtz_dly;
    s_wr(8'h44) |=> return_to_zero_delay ==
      (wd_ff[4:3] == 2'h0 ? 4'h0 : {1'b0, wd_ff[4:3] - 2'h1, 1'b1});
  endproperty
  property p_rtz_wid;
    s_wr(8'h44) |=> return_to_zero_width == {1'b0, wd_ff[2:0]} + 4'h1;
  endproperty
  property p_meas;
    (!thermal_shutdown && !conv_meas_en && !reg_wr)[*3] |=> !thermal_shutdown;
  endproperty
  property p_trip;
    s_hot |=> thermal_shutdown;
  endproperty
  property p_resume;
    s_cool |=> !thermal_shutdown;
  endproperty
  property p_hold;
    thermal_shutdown && !reg_wr && !$past(reg_wr) && !die_temp_valid
      && !$past(die_temp_valid) |=> thermal_shutdown;
  endproperty
  property p_tsd_off;
    (!tsd_en_ff)[*2] |-> !thermal_shutdown;
  endproperty
  a_peak: assert property (p_peak) else $error("peak load missing");
  a_dac: assert property (p_dac) else $error("test level wrong");
  a_rtz_dly: assert property (p_rtz_dly) else $error("delay wrong");
  a_rtz_wid: assert property (p_rtz_wid) else $error("width wrong");
  a_meas: assert property (p_meas) else $error("trip while idle");
  a_trip: assert property (p_trip) else $error("no shutdown");
  a_resume: assert property (p_resume) else $error("no recovery");
  a_hold: assert property (p_hold) else $error("shutdown dropped");
  a_tsd_off: assert property (p_tsd_off) else $error("shutdown disabled");
endmodule
bind ldt_ctrl ldt_chk u_ldt_chk
(
  .sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .conv_meas_en(conv_meas_en), .peak_load(peak_load),
  .peak_load_data(peak_load_data), .test_dac_level(test_dac_level),
  .return_to_zero_delay(return_to_zero_delay), .return_to_zero_width(return_to_zero_width),
  .die_temp(die_temp), .die_temp_valid(die_temp_valid), .thermal_shutdown(thermal_shutdown)
);

/* File: tb/ldt_analog.sv */
// Analog front-end model: temperature converter and heater sense
`timescale 1ns/1ps
module ldt_analog
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  // Bench request for one temperature result
  input  wire logic       temp_req,
  input  wire logic [7:0] temp_val,
  // Block side
  input  wire logic       heater_sample,
  output logic [7:0]      die_temp,
  output logic            die_temp_valid,
  output logic [7:0]      heater_level,
  output logic [7:0]      conv_result
);
  // Idle data toggles so a stale value never looks valid
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      die_temp       <= 8'h00;
      die_temp_valid <= 1'b0;
    end
    else
    begin
      die_temp_valid <= temp_req;
      die_temp       <= temp_req ? temp_val : ~die_temp;
    end
  end
  // Heater sense moves only when sampled
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      heater_level <= 8'h00;
    else if (heater_sample)
      heater_level <= heater_level + 8'h13;
  end
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      conv_result <= 8'h00;
    else
      conv_result <= conv_result + 8'h01;
  end
endmodule

/* File: tb/tb.sv */
// Self-checking bench for the laser driver control block
`timescale 1ns/1ps
module tb;
  import ldt_pkg::*;
  logic          sys_clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, temp_req = 0, rd_seen = 0;
  logic [7:0]    reg_addr = 8'h00, temp_val = 8'h00, peak_load_data, test_dac_level, setpt;
  ldt_byte_t     reg_wdata = 8'h00, reg_rdata, conv_result, heater_level, die_temp, d;
  logic [3:0]    dly, wid;
  logic [1:0]    peak_mode, ref_sel;
  logic          meas_en, peak_load, heater_sample, heater_active, die_temp_valid, tsd;
  logic          en1, en2, en3;
  ldt_htr_mode_t heater_mode;
  logic [31:0]   lfsr = 32'h1b64;
  int            mismatches = 0, check_count = 0, n;
  ldt_byte_t     rd_q[$];
  ldt_byte_t     dly_tab[4] = '{8'h00, 8'h01, 8'h03, 8'h05};
  initial
  begin
    forever #5 sys_clk = ~sys_clk;
  end
  ldt_ctrl dut
  (
    .sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_result(conv_result),
    .conv_meas_en(meas_en), .peak_load(peak_load), .peak_load_data(peak_load_data),
    .peak_detect_mode(peak_mode), .test_dac_level(test_dac_level),
    .return_to_zero_en_ch1(en1), .return_to_zero_en_ch2(en2), .return_to_zero_en_ch3(en3),
    .return_to_zero_delay(dly), .return_to_zero_width(wid), .heater_level(heater_level),
    .heater_sample(heater_sample), .heater_ref_sel(ref_sel), .heater_mode(heater_mode),
    .heater_active(heater_active), .heater_target_setpoint(setpt), .die_temp(die_temp),
    .die_temp_valid(die_temp_valid), .thermal_shutdown(tsd)
  );
  ldt_analog u_analog
  (
    .sys_clk(sys_clk), .rst_b(rst_b), .temp_req(temp_req), .temp_val(temp_val),
    .heater_sample(heater_sample), .die_temp(die_temp), .die_temp_valid(die_temp_valid),
    .heater_level(heater_level), .conv_result(conv_result)
  );
  function automatic logic [31:0] lfsr_step(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(logic [15:0] got, logic [15:0] exp);
    check_count++;
    if (got !== exp)
      $display("CHECK FAILED %0t: got %h expected %h", $time, got, exp);
    if (got !== exp)
      mismatches++;
  endtask
  // One register access; reads leave their expectation in the queue
  task automatic acc(logic w, logic [7:0] a, ldt_byte_t v);
    @(posedge sys_clk);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= v;
    if (!w)
      rd_q.push_back(v);
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1;
  endtask
  task automatic heat(ldt_byte_t v, logic exp);
    @(posedge sys_clk);
    temp_req <= 1'b1;
    temp_val <= v;
    @(posedge sys_clk);
    temp_req <= 1'b0;
    repeat (5) @(posedge sys_clk);
    #1;
    chk(16'(tsd), 16'(exp));
  endtask
  task automatic gap();
    n = 0;
    do
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    while (!heater_sample && n < 1100);
    if (n >= 1100)
    begin
      mismatches++;
      results();
    end
  endtask
  task automatic results();
    if (mismatches == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge sys_clk)
  begin
    if (rd_seen)
      chk(16'(reg_rdata), 16'(rd_q.pop_front()));
    rd_seen <= reg_rd;
  end
  initial
  begin
    repeat (5) @(posedge sys_clk);
    rst_b <= 1'b1;
    acc(0, 8'h4c, 8'h40);
    acc(0, 8'h4d, 8'h60);
    acc(0, 8'h4e, 8'hff);
    acc(0, 8'hff, 8'h00);
    acc(1, 8'h4b, 8'h5a);
    acc(0, 8'h4b, heater_level);
    for (int i = 0; i < 8; i++)
    begin
      lfsr = lfsr_step(lfsr);
      d = {lfsr[7:5], i[1:0], i[2:0]};
      acc(1, 8'h44, d);
      chk(16'({en3, en2, en1}), 16'(d[7:5]));
      chk(16'(dly), 16'(dly_tab[i[1:0]]));
      chk(16'(wid), 16'(i + 1));
      acc(0, 8'h44, d);
      acc(1, 8'h4a, ~lfsr[15:8]);
      chk(16'(setpt), {8'h00, ~lfsr[15:8]});
      acc(1, 8'h49, {i[2:0], i[1:0], i[2:0]});
      chk(16'(heater_mode), 16'(i));
      chk(16'(ref_sel), 16'(i[1:0]));
      chk(16'(heater_active), 16'(i == 1 || i == 4 || i == 5));
      acc(1, 8'h49, {i[2:0], 5'h01});
      gap();
      gap();
      chk(16'(n), 16'(4 << i));
    end
    acc(1, 8'h49, 8'h00);
    acc(0, 8'h4b, heater_level);
    lfsr = lfsr_step(lfsr);
    d = lfsr[7:0];
    acc(1, 8'h42, 8'h82);
    acc(1, 8'h43, d);
    chk(16'(peak_load), 16'h0001);
    chk(16'(peak_mode), 16'h0002);
    chk(16'(peak_load_data), 16'(d));
    chk(16'(test_dac_level), 16'(d));
    acc(1, 8'h42, 8'h00);
    acc(1, 8'h43, ~d);
    chk(16'(peak_load), 16'h0000);
    acc(1, 8'h42, 8'h40);
    @(posedge sys_clk);
    #1;
    chk(16'(peak_load), 16'h0001);
    chk(16'(peak_load_data), {8'h00, ~d});
    acc(0, 8'h42, 8'h00);
    chk(16'(test_dac_level), 16'(d));
    acc(1, 8'h07, 8'h28);
    acc(1, 8'h41, 8'h40);
    chk(16'(meas_en), 16'h0001);
    acc(1, 8'h4c, 8'h50);
    acc(1, 8'h4d, 8'h70);
    heat(8'h50, 1'b0);
    heat(8'h4f, 1'b1);
    heat(8'h70, 1'b1);
    heat(8'h71, 1'b0);
    heat(8'h10, 1'b1);
    acc(0, 8'h4e, 8'h10);
    acc(1, 8'h07, 8'h08);
    heat(8'h10, 1'b0);
    heat(8'h80, 1'b0);
    acc(1, 8'h41, 8'h00);
    chk(16'(meas_en), 16'h0000);
    acc(1, 8'h07, 8'h28);
    heat(8'h05, 1'b0);
    acc(0, 8'h4e, 8'h80);
    repeat (2) @(posedge sys_clk);
    results();
  end
endmodule
